// >>> port_b_pkg.sv
// package: constants and carrier types for the second general-purpose port
package port_b_pkg;

    localparam int PORT_WIDTH      = 8;
    localparam int CHANGE_LO_BIT   = 4;
    localparam int CHANGE_HI_BIT   = 7;
    localparam int EXT_IRQ_BIT     = 0;
    localparam int SLAVE_SEL_BIT   = 1;
    localparam int ANALOG8_BIT     = 2;
    localparam int ANALOG9_BIT     = 3;
    localparam int PROG_CLOCK_BIT  = 6;
    localparam int PROG_DATA_BIT   = 7;
    localparam int CHANGE_FLAG_BIT = 0;
    localparam int SYNC_STAGES     = 2;

    localparam logic [7:0] LATCH_RESET   = 8'h00;
    localparam logic [7:0] DIR_RESET     = 8'hff;
    localparam logic [3:0] REF_RESET     = 4'h0;
    localparam logic       FLAG_RESET    = 1'b0;
    localparam logic       PULLUP_RESET  = 1'b0;

    // software access to the port data register
    typedef struct packed {
        logic       readStrobe;
        logic       writeStrobe;
        logic [7:0] writeData;
    } port_access_s;

    // alternate function inputs seen through the port pins
    typedef struct packed {
        logic extIrq;
        logic slaveSelect;
        logic progClock;
        logic progData;
        logic analogCh8Enable;
        logic analogCh9Enable;
    } alt_func_s;

endpackage

// >>> pin_sync.sv
// two-flop synchroniser for the port pin inputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage1_next;
    logic [WIDTH-1:0] stage2_next;

    always_comb begin
        stage1_next = asyncIn;
        stage2_next = stage1_reg;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
        end
    end

    assign syncOut = stage2_reg;
endmodule
`default_nettype wire

// >>> second_io_port.sv
// second general-purpose port with pull-ups, alternate functions and change detection
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// RULE1: only pins four to seven take part in change detection.
// RULE2: upper pins set as outputs are left out of the comparison.
// RULE3: each upper input is compared with the value latched at last port read.
// RULE4: per-pin mismatches are ORed to set the change flag, control bit zero.
// RULE5: a pending change flag raises the wake-from-sleep output.
// RULE6: any port read or write reloads the comparison reference.
// RULE7: flag keeps setting while mismatch lasts; clear works only after access.
// RULE8: software should not poll the port while using change interrupts.
// RULE9: every pin has a weak pull-up enabled by software for inputs.
// RULE10: pin zero also feeds the external interrupt input.
// RULE11: pin one also feeds the serial unit slave select.
// RULE12: pin two also serves as analog channel eight.
// RULE13: pin three also serves as analog channel nine and low-voltage input. Here there is no low-voltage input.
// RULE14: pins six and seven carry programming clock and data.
// RULE15: change is compared every cycle; flag sets within one cycle. Here a pin change sets it three edges later.
module second_io_port
    import port_b_pkg::*;
#(
    parameter int WIDTH = PORT_WIDTH
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire port_access_s     portAccess,
    output logic      [WIDTH-1:0] portReadData,
    input  wire logic             dirWrite,
    input  wire logic [WIDTH-1:0] dirWriteData,
    output logic      [WIDTH-1:0] dirState,
    input  wire logic             pullupEnable,
    input  wire logic             flagClear,
    output logic      [7:0]       interrupt_control_reg,
    output logic                  port_change_flag,
    output logic                  wakeRequest,
    input  wire logic             analogCh8Select,
    input  wire logic             analogCh9Select,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinOut,
    output logic      [WIDTH-1:0] pinOutEnable,
    output logic      [WIDTH-1:0] pinPullup,
    output alt_func_s             altFunc
);
    localparam int NIB = CHANGE_HI_BIT - CHANGE_LO_BIT + 1;

    logic [WIDTH-1:0] pinSync;
    logic [WIDTH-1:0] latch_reg;
    logic [WIDTH-1:0] latch_next;
    logic [WIDTH-1:0] dir_reg;
    logic [WIDTH-1:0] dir_next;
    logic [NIB-1:0]   ref_reg;
    logic [NIB-1:0]   ref_next;
    logic             flag_reg;
    logic             flag_next;
    logic [WIDTH-1:0] readData_reg;
    logic [WIDTH-1:0] readData_next;
    logic [NIB-1:0]   mismatch;
    logic             anyMismatch;
    logic             portTouched;
    logic [WIDTH-1:0] pinLevel;

    // registered pad controls and alternate-function word
    logic [WIDTH-1:0] pullup_reg;
    logic [WIDTH-1:0] pullup_next;
    alt_func_s        altFunc_reg;
    alt_func_s        altFunc_next;

    ////////////////////////////////////////////////////////////////////////////
    // pins pass two flops before anything reads them
    pin_sync #(
        .WIDTH (WIDTH)
    ) u_sync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .asyncIn (pinIn),
        .syncOut (pinSync)
    );

    // per pin: read-back source, drive enable and pull-up request
    genvar p;
    generate
        for (p = 0; p < WIDTH; p++) begin : g_pin
            // an output pin reads back its own latch, an input the pin
            assign pinLevel[p]     = dir_reg[p] ? pinSync[p] : latch_reg[p];
            // drive only where the direction says output
            assign pinOutEnable[p] = ~dir_reg[p];
            // pull-up only where the pin is an input [RULE9]
            assign pullup_next[p]  = pullupEnable & dir_reg[p];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // change comparison on the upper nibble
    genvar g;
    generate
        for (g = 0; g < NIB; g++) begin : g_cmp
            // output pins are masked off the comparison [RULE1] [RULE2] [RULE3]
            assign mismatch[g] = dir_reg[CHANGE_LO_BIT + g]
                               & (pinSync[CHANGE_LO_BIT + g] ^ ref_reg[g]);
        end
    endgenerate

    assign anyMismatch = |mismatch;  // [RULE4] [RULE15]
    assign portTouched = portAccess.readStrobe | portAccess.writeStrobe;

    ////////////////////////////////////////////////////////////////////////////
    // output latch and direction; a direction bit of one makes the pin an input
    always_comb begin
        latch_next = latch_reg;
        dir_next   = dir_reg;
        if (portAccess.writeStrobe) begin
            latch_next = portAccess.writeData;
        end
        if (dirWrite) begin
            dir_next = dirWriteData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            latch_reg <= WIDTH'(LATCH_RESET);
            dir_reg   <= WIDTH'(DIR_RESET);
        end else begin
            latch_reg <= latch_next;
            dir_reg   <= dir_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read capture: one cycle after the strobe the word stands until the next read
    always_comb begin
        readData_next = readData_reg;
        if (portAccess.readStrobe) begin
            readData_next = pinLevel;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            readData_reg <= WIDTH'(LATCH_RESET);
        end else begin
            readData_reg <= readData_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // comparison reference and change flag
    // reference resets low, so an input held high flags until the port is touched
    always_comb begin
        ref_next  = ref_reg;
        flag_next = flag_reg;
        // reload reference on any access, ending the mismatch [RULE6]
        // a write reloads from the pins too, not from the written data
        if (portTouched) begin
            ref_next = pinSync[CHANGE_HI_BIT:CHANGE_LO_BIT];
        end
        if (flagClear) begin
            flag_next = 1'b0;
        end
        // set beats clear; a live mismatch keeps the flag up [RULE7] [RULE4]
        // access and clear in one cycle still see the old reference
        if (anyMismatch) begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ref_reg  <= REF_RESET;
            flag_reg <= FLAG_RESET;
        end else begin
            ref_reg  <= ref_next;
            flag_reg <= flag_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pull-up requests, registered so the pad control never glitches
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pullup_reg <= {WIDTH{PULLUP_RESET}};
        end else begin
            pullup_reg <= pullup_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // alternate functions; schmitt buffering lives in the pad itself
    // registered, so each digital use sees the pin one cycle after the port does
    always_comb begin
        altFunc_next.extIrq          = pinSync[EXT_IRQ_BIT];     // [RULE10]
        altFunc_next.slaveSelect     = pinSync[SLAVE_SEL_BIT];   // [RULE11]
        altFunc_next.progClock       = pinSync[PROG_CLOCK_BIT];  // [RULE14]
        altFunc_next.progData        = pinSync[PROG_DATA_BIT];   // [RULE14]
        altFunc_next.analogCh8Enable = analogCh8Select & dir_reg[ANALOG8_BIT];  // [RULE12]
        altFunc_next.analogCh9Enable = analogCh9Select & dir_reg[ANALOG9_BIT];  // [RULE13]
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            altFunc_reg <= '0;
        end else begin
            altFunc_reg <= altFunc_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign portReadData          = readData_reg;
    assign dirState              = dir_reg;
    assign port_change_flag      = flag_reg;
    assign interrupt_control_reg = {7'h00, flag_reg};
    // wake follows the flag itself; no enable gates it inside the port
    assign wakeRequest           = flag_reg;  // [RULE5]
    assign pinOut                = latch_reg;
    assign pinPullup             = pullup_reg;
    assign altFunc               = altFunc_reg;

endmodule
`default_nettype wire

// >>> port_b_chk.sv
// checker: change flag, read capture and pin control relations of the port
`timescale 1ns/100ps
`default_nettype none
module port_b_chk
    import port_b_pkg::*;
(
    input wire logic         sys_clk,
    input wire logic         sys_rst,
    input wire port_access_s portAccess,
    input wire logic [7:0]   portReadData,
    input wire logic [7:0]   dirState,
    input wire logic         pullupEnable,
    input wire logic         flagClear,
    input wire logic [7:0]   interrupt_control_reg,
    input wire logic         port_change_flag,
    input wire logic         wakeRequest,
    input wire logic         analogCh8Select,
    input wire logic         analogCh9Select,
    input wire logic [7:0]   pinIn,
    input wire logic [7:0]   pinOut,
    input wire logic [7:0]   pinOutEnable,
    input wire logic [7:0]   pinPullup,
    input wire alt_func_s    altFunc
);
default clocking @(posedge sys_clk); endclocking
default disable iff (sys_rst);
////////////////////////////////////////////////////////////////////////////////
chk_flag_mirror: assert property (interrupt_control_reg == {7'h00, port_change_flag})
    else $error("control bit zero differs from flag");
chk_wake_flag: assert property (wakeRequest == port_change_flag)
    else $error("wake request differs from flag");
chk_pullup_dir: assert property (!$past(sys_rst) |->
    pinPullup == ($past({8{pullupEnable}}) & $past(dirState)))
    else $error("pull-up not limited to inputs");
chk_analog_eight: assert property (!$past(sys_rst) |->
    altFunc.analogCh8Enable == ($past(analogCh8Select) & $past(dirState[ANALOG8_BIT])))
    else $error("analog eight enable wrong");
chk_analog_nine: assert property (!$past(sys_rst) |->
    altFunc.analogCh9Enable == ($past(analogCh9Select) & $past(dirState[ANALOG9_BIT])))
    else $error("analog nine enable wrong");
chk_drive_dir: assert property (pinOutEnable == ~dirState)
    else $error("output enable disagrees with direction");
// pins lag two sync stages, so the captured value is three samples old one edge later
chk_read_capture: assert property (portAccess.readStrobe |=> portReadData ==
    (($past(pinIn, 3) & $past(dirState)) | ($past(pinOut) & ~$past(dirState))))
    else $error("read data not pins and latch");
chk_clear_after: assert property (($stable(pinIn) [*3] ##0 portAccess.readStrobe)
    ##[1:2] (flagClear && $stable(pinIn)) |=> !port_change_flag)
    else $error("clear after read did not take");
chk_out_excluded: assert property (dirState[7:4] == 4'h0 && !port_change_flag
    |=> !port_change_flag)
    else $error("flag set with upper pins as outputs");
cov_flag_set: cover property ($rose(port_change_flag));
cov_flag_clear: cover property ($fell(port_change_flag));
cov_read_clear: cover property (portAccess.readStrobe ##2 flagClear);
endmodule
bind second_io_port port_b_chk port_b_chk_inst (.*);
`default_nettype wire

// >>> key_bank.sv
// partner: keys and outside logic on the port pins
`timescale 1ns/100ps
`default_nettype none
module key_bank (
    input wire logic       sys_clk,
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOutEnable,
    input wire logic [7:0] pinPullup,
    input wire logic [7:0] keyDrive,
    input wire logic [7:0] keyLevel,
    output logic     [7:0] pinIn
);
    logic flip = 1'b0;
    // a floating pin wanders so stale levels never pass for real ones
    always @(posedge sys_clk) flip <= ~flip;
    assign pinIn = (pinOutEnable & pinOut) | (~pinOutEnable & keyDrive & keyLevel)
                 | (~pinOutEnable & ~keyDrive & (pinPullup | {8{flip}}));
endmodule
`default_nettype wire

// >>> testbench.sv
// testbench: port change detection, read capture, direction and alternate pin uses
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import port_b_pkg::*;
    logic sys_clk = 1'b0, sys_rst = 1'b1, dirWrite = 1'b0, pullupEnable = 1'b0, flagClear = 1'b0;
    logic analogCh8Select = 1'b0, analogCh9Select = 1'b0, port_change_flag, wakeRequest;
    logic [7:0] dirWriteData = 8'hff, keyDrive = 8'hff, keyLevel = 8'h00, portReadData;
    logic [7:0] dirState, interrupt_control_reg, pinIn, pinOut, pinOutEnable, pinPullup;
    port_access_s portAccess = '0;
    alt_func_s    altFunc;
    int           miscompares = 0, n_tests = 0;
    always #25 sys_clk = ~sys_clk;
    second_io_port second_io_port_inst (.*);
    key_bank key_bank_inst (.*);
////////////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic settle;
        @(negedge sys_clk);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd;
        step(1);
        portAccess.readStrobe <= 1'b1;
        step(1);
        portAccess.readStrobe <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] d);
        step(1);
        portAccess.writeStrobe <= 1'b1;
        portAccess.writeData <= d;
        step(1);
        portAccess.writeStrobe <= 1'b0;
    endtask
    task automatic clr;
        step(1);
        flagClear <= 1'b1;
        step(1);
        flagClear <= 1'b0;
    endtask
    task automatic conclude;
        $display("tests %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3000) @(posedge sys_clk);
        miscompares++;
        conclude;
    end
    initial begin
        step(6);
        sys_rst <= 1'b0;
        step(1);
        keyLevel <= 8'h0f;
        step(5);
        settle;
        chk({7'h00, port_change_flag}, 8'h00);
        for (int b = 4; b < 8; b++) begin
            step(1);
            keyLevel <= 8'h01 << b;
            step(4);
            settle;
            chk({7'h00, port_change_flag}, 8'h01);
            chk(interrupt_control_reg, 8'h01);
            chk({7'h00, wakeRequest}, 8'h01);
            clr;
            settle;
            chk({7'h00, port_change_flag}, 8'h01);
            if (b % 2) begin
                rd;
                settle;
                chk(portReadData, 8'h01 << b);
            end else wr(8'h00);
            clr;
            settle;
            chk({7'h00, port_change_flag}, 8'h00);
            step(1);
            keyLevel <= 8'h00;
            step(4);
            rd; // one access per change, no polling
            clr;
        end
        step(1);
        keyLevel <= 8'hc3;
        analogCh8Select <= 1'b1;
        analogCh9Select <= 1'b1;
        step(4);
        settle;
        chk({2'b00, altFunc}, 8'h3f);
        step(1);
        keyLevel <= 8'h00;
        step(4);
        rd;
        clr;
        step(1);
        dirWrite <= 1'b1;
        dirWriteData <= 8'h0f;
        step(1);
        dirWrite <= 1'b0;
        keyDrive <= 8'h0f;
        wr(8'hf0);
        step(5);
        settle;
        chk({7'h00, port_change_flag}, 8'h00);
        chk(pinOutEnable, 8'hf0);
        chk(pinOut, 8'hf0);
        chk(dirState, 8'h0f);
        rd;
        settle;
        chk(portReadData, 8'hf0);
        step(1);
        pullupEnable <= 1'b1;
        step(1);
        settle;
        chk(pinPullup, 8'h0f);
        conclude;
    end
endmodule
`default_nettype wire
